// *** core/status_led_driver.sv ***
// Status indicator driver: run, error and per-port link/activity pins.
// Assumes an AHB-Lite master on sys_clk and board pull resistors on the pins.
`include "led_defines.svh"

// Functional notes
// - One run output, one error output, three port link/activity outputs.
// - Per-pin polarity field in hardware configuration, defaulting from five straps.
// - A pin that doubles as a strap defaults to the inverse strap polarity.
// - The error output drives only while its enable bit is set or an EEPROM load error enables it.
// - Port 0 and port 2 pins never swap with chip mode.
// - Software override registers replace the run and error states.
// - The indicator disable bit releases every indicator pin.
// - EEPROM load error enables the error output when it is active low.
// - In combined mode the run output is off while error is on.
// - The state-run mode bit selects combined behaviour for the run output.
// - The core configuration register loads from EEPROM contents.
// - Each pin drives only its active level and otherwise floats.
module status_led_driver #(
    parameter int BLINK_CYC = `ACT_BLINK_CYC
) (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 sys_rst,
    // AHB-Lite slave
    input  wire logic                 hsel,
    input  wire led_pkg::addr_t       haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire led_pkg::word_t       hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output led_pkg::word_t            hrdata,
    // Straps and core state
    input  wire led_pkg::polarity_t   indicator_polarity_straps,
    input  wire logic                 run_state,
    input  wire logic                 error_state,
    input  wire led_pkg::port_vec_t   port_link,
    input  wire led_pkg::port_vec_t   port_frame,
    // EEPROM loader
    input  wire logic                 eeprom_load_done,
    input  wire logic                 eeprom_load_error,
    input  wire logic [1:0]           eeprom_core_config,
    // Indicator pins
    output logic                      run_indicator,
    output logic                      run_indicator_oe_n,
    output logic                      error_indicator,
    output logic                      error_indicator_oe_n,
    output led_pkg::port_vec_t        port_link_activity_indicator,
    output led_pkg::port_vec_t        port_link_activity_indicator_oe_n
);
    import led_pkg::*;

    // Register state.
    polarity_t   polarity;
    logic [1:0]  core_config;
    logic [1:0]  run_override;
    logic [1:0]  err_override;
    logic        indicator_disable;
    logic        eeprom_error;
    polarity_t   next_polarity;
    logic [1:0]  next_core_config;
    logic [1:0]  next_run_override;
    logic [1:0]  next_err_override;
    logic        next_indicator_disable;
    logic        next_eeprom_error;

    // Bus state.
    logic        wr_pending;
    addr_t       wr_addr;
    logic        next_wr_pending;
    addr_t       next_wr_addr;
    word_t       next_hrdata;

    // Strap capture.
    strap_load_e load_state;
    strap_load_e next_load_state;
    logic [2:0]  settle;
    logic [2:0]  next_settle;
    polarity_t   strap_level;

    // Pin state.
    logic        run_on;
    logic        err_on;
    logic        err_allowed;
    port_vec_t   port_lit;
    logic        next_run_indicator;
    logic        next_run_indicator_oe_n;
    logic        next_error_indicator;
    logic        next_error_indicator_oe_n;
    port_vec_t   next_port_level;
    port_vec_t   next_port_oe_n;

    function automatic logic addr_phase(input logic sel, input logic [1:0] trans,
                                        input logic rdy);
        addr_phase = sel && trans == `HTRANS_NONSEQ && rdy;
    endfunction

    // Open drain when active low, open source when active high.
    function automatic logic release_n(input logic on, input logic off_all);
        release_n = !(on && !off_all);
    endfunction

    strap_sync u_strap_sync (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .pins    (indicator_polarity_straps),
        .level   (strap_level)
    );

    // Fixed port-to-pin order, independent of any chip mode.
    for (genvar p = 0; p < `PORTS; p++) begin : g_port
        activity_blink #(
            .BLINK_CYC (BLINK_CYC)
        ) u_activity (
            .sys_clk (sys_clk),
            .sys_rst (sys_rst),
            .link    (port_link[p]),
            .frame   (port_frame[p]),
            .lit     (port_lit[p])
        );
    end

    // Straps are caught only after the synchroniser has filled past reset.
    always_comb begin
        next_load_state = load_state;
        next_settle     = settle;
        case (load_state)
            LOAD_SETTLE: begin
                next_settle = settle + 1'b1;
                if (settle == `STRAP_SETTLE) begin
                    next_load_state = LOAD_TAKE;
                end
            end
            LOAD_TAKE: next_load_state = LOAD_RUN;
            LOAD_RUN:  next_load_state = LOAD_RUN;
            default:   next_load_state = LOAD_SETTLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            load_state <= LOAD_SETTLE;
            settle     <= '0;
        end else begin
            load_state <= next_load_state;
            settle     <= next_settle;
        end
    end

    // Bus address phase and read data; no wait states, always OKAY.
    always_comb begin
        next_wr_pending = addr_phase(hsel, htrans, hready) && hwrite;
        next_wr_addr    = wr_addr;
        next_hrdata     = hrdata;
        if (addr_phase(hsel, htrans, hready)) begin
            next_wr_addr = haddr;
            if (!hwrite) begin
                case (haddr)
                    `OFS_HARDWARE_CONF: next_hrdata = 32'(polarity);
                    `OFS_CORE_CONF:     next_hrdata = 32'(core_config);
                    `OFS_RUN_OVERRIDE:  next_hrdata = 32'(run_override);
                    `OFS_ERR_OVERRIDE:  next_hrdata = 32'(err_override);
                    `OFS_POWER_CONTROL: next_hrdata = 32'(indicator_disable);
                    `OFS_STATUS: next_hrdata = 32'({error_indicator_oe_n,
                                                    run_indicator_oe_n,
                                                    eeprom_error, port_link});
                    default:            next_hrdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wr_pending <= 1'b0;
            wr_addr    <= '0;
            hrdata     <= '0;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
        end else begin
            wr_pending <= next_wr_pending;
            wr_addr    <= next_wr_addr;
            hrdata     <= next_hrdata;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
        end
    end

    // Register writes in the data phase; loader events win over software.
    always_comb begin
        next_polarity          = polarity;
        next_core_config       = core_config;
        next_run_override      = run_override;
        next_err_override      = err_override;
        next_indicator_disable = indicator_disable;
        next_eeprom_error      = eeprom_error;
        if (wr_pending) begin
            case (wr_addr)
                `OFS_HARDWARE_CONF: next_polarity = hwdata[`POL_W-1:0];
                `OFS_CORE_CONF:     next_core_config = hwdata[1:0];
                `OFS_RUN_OVERRIDE:  next_run_override = hwdata[1:0];
                `OFS_ERR_OVERRIDE:  next_err_override = hwdata[1:0];
                `OFS_POWER_CONTROL: next_indicator_disable = hwdata[`PWR_IND_DIS];
                default:            next_polarity = polarity;
            endcase
        end
        if (load_state == LOAD_TAKE) begin
            next_polarity = strap_level ^ `STRAP_SHARED_MASK;
        end
        if (eeprom_load_done) begin
            next_core_config  = eeprom_core_config;
            next_eeprom_error = 1'b0;
        end
        if (eeprom_load_error) begin
            next_eeprom_error = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            polarity          <= '0;
            core_config       <= `CORE_CONF_RST;
            run_override      <= '0;
            err_override      <= '0;
            indicator_disable <= 1'b0;
            eeprom_error      <= 1'b0;
        end else begin
            polarity          <= next_polarity;
            core_config       <= next_core_config;
            run_override      <= next_run_override;
            err_override      <= next_err_override;
            indicator_disable <= next_indicator_disable;
            eeprom_error      <= next_eeprom_error;
        end
    end

    // Pin levels. A strapped error pin may be tied low on the board, so it
    // stays released unless enabled; driving it there would fight the tie.
    always_comb begin
        err_on = err_override[`OVR_EN] ? err_override[`OVR_VAL] : error_state;
        err_allowed = core_config[`CFG_ERR_EN]
                      || (eeprom_error && !polarity[`POL_ERR]);
        run_on = run_override[`OVR_EN] ? run_override[`OVR_VAL] : run_state;
        if (core_config[`CFG_STATE_MODE] && err_on && err_allowed) begin
            run_on = 1'b0;
        end
        next_run_indicator        = polarity[`POL_RUN];
        next_run_indicator_oe_n   = release_n(run_on, indicator_disable);
        next_error_indicator      = polarity[`POL_ERR];
        next_error_indicator_oe_n = release_n(err_on && err_allowed,
                                              indicator_disable);
        for (int p = 0; p < `PORTS; p++) begin
            next_port_level[p] = polarity[p];
            next_port_oe_n[p]  = release_n(port_lit[p], indicator_disable);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            run_indicator                     <= 1'b0;
            run_indicator_oe_n                <= 1'b1;
            error_indicator                   <= 1'b0;
            error_indicator_oe_n              <= 1'b1;
            port_link_activity_indicator      <= '0;
            port_link_activity_indicator_oe_n <= '1;
        end else begin
            run_indicator                     <= next_run_indicator;
            run_indicator_oe_n                <= next_run_indicator_oe_n;
            error_indicator                   <= next_error_indicator;
            error_indicator_oe_n              <= next_error_indicator_oe_n;
            port_link_activity_indicator      <= next_port_level;
            port_link_activity_indicator_oe_n <= next_port_oe_n;
        end
    end

    // Checks on the pin behaviour, the loaded registers and the bus answer.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_disable_set;
        indicator_disable;
    endsequence

    sequence s_all_released;
        run_indicator_oe_n && error_indicator_oe_n
        && (&port_link_activity_indicator_oe_n);
    endsequence

    chk_disable_releases: assert property (s_disable_set |=> s_all_released)
        else $error("indicator disable did not release all pins");

    chk_error_enable_gate: assert property (
        !core_config[`CFG_ERR_EN] && !eeprom_error |=> error_indicator_oe_n)
        else $error("error pin driven while not enabled");

    chk_eeprom_force_err: assert property (
        eeprom_error && !polarity[`POL_ERR] && error_state && !err_override[`OVR_EN]
        && !indicator_disable |=> !error_indicator_oe_n)
        else $error("error pin not forced after eeprom load error");

    // The pins lag the registers by one edge, so the mode is the one of the cycle before.
    chk_combined_run_off: assert property (
        $past(core_config[`CFG_STATE_MODE]) && !error_indicator_oe_n |-> run_indicator_oe_n)
        else $error("run pin driven while error on in combined mode");

    chk_plain_run_mode: assert property (
        !core_config[`CFG_STATE_MODE] && !run_override[`OVR_EN] && run_state
        && !indicator_disable |=> !run_indicator_oe_n)
        else $error("run pin off outside combined mode");

    chk_run_override_val: assert property (
        run_override == 2'h1 |=> run_indicator_oe_n)
        else $error("run override off value not obeyed");

    chk_eeprom_load_cfg: assert property (
        eeprom_load_done |=> core_config == $past(eeprom_core_config))
        else $error("core configuration not loaded from eeprom");

    chk_strap_inverse: assert property (
        load_state == LOAD_TAKE |=> polarity == ($past(strap_level) ^ `STRAP_SHARED_MASK))
        else $error("strap polarity default not taken");

    chk_drive_level: assert property (
        ##1 run_indicator == $past(polarity[`POL_RUN])
        && error_indicator == $past(polarity[`POL_ERR]))
        else $error("pin driven to a level other than its active level");

    chk_port_fixed: assert property (
        !port_link[0] |=> ##1 port_link_activity_indicator_oe_n[0] || indicator_disable)
        else $error("port 0 pin follows another port");

    chk_port_two_fixed: assert property (
        !port_link[2] |=> ##1 port_link_activity_indicator_oe_n[2] || indicator_disable)
        else $error("port 2 pin follows another port");

    chk_error_override_off: assert property (
        err_override[`OVR_EN] && !err_override[`OVR_VAL] |=> error_indicator_oe_n)
        else $error("error override off value not obeyed");

    chk_eeprom_error_sticky: assert property (
        eeprom_load_error |=> eeprom_error)
        else $error("eeprom load error flag not set");

    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
endmodule

// *** common/led_defines.svh ***
// Constants of the status indicator driver: offsets, fields, resets, times.
// Assumes a 200 MHz system clock and a byte-addressed AHB-Lite slave port.
`ifndef LED_DEFINES_SVH
`define LED_DEFINES_SVH

`define ADDR_W             8
`define OFS_HARDWARE_CONF  8'h00
`define OFS_CORE_CONF      8'h04
`define OFS_RUN_OVERRIDE   8'h08
`define OFS_ERR_OVERRIDE   8'h0c
`define OFS_POWER_CONTROL  8'h10
`define OFS_STATUS         8'h14

`define PORTS              3
`define POL_W              5
`define POL_RUN            3
`define POL_ERR            4
`define STRAP_SHARED_MASK  5'h18
`define CFG_ERR_EN         0
`define CFG_STATE_MODE     1
`define CORE_CONF_RST      2'h0
`define OVR_EN             0
`define OVR_VAL            1
`define PWR_IND_DIS        0
`define HTRANS_NONSEQ      2'h2

`define STRAP_SETTLE       3'h4
`define CLK_MHZ            200
`define ACT_BLINK_MS       20
`define ACT_BLINK_CYC      (`ACT_BLINK_MS * `CLK_MHZ * 1000)
`define ACT_CNT_W          23

`endif

// *** common/led_pkg.sv ***
// Types shared by the status indicator driver files.
// Assumes led_defines.svh is on the include path.
`include "led_defines.svh"
package led_pkg;
    typedef logic [`POL_W-1:0]   polarity_t;
    typedef logic [`PORTS-1:0]   port_vec_t;
    typedef logic [31:0]         word_t;
    typedef logic [`ADDR_W-1:0]  addr_t;
    typedef enum logic [1:0] {LOAD_SETTLE, LOAD_TAKE, LOAD_RUN} strap_load_e;
endpackage

// *** core/strap_sync.sv ***
// Three-stage synchroniser for strap pins with an agreement filter.
// Assumes the inputs are asynchronous to sys_clk.
`include "led_defines.svh"
module strap_sync (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 sys_rst,
    // Pins and filtered result
    input  wire led_pkg::polarity_t   pins,
    output led_pkg::polarity_t        level
);
    import led_pkg::*;

    polarity_t stage1;
    polarity_t stage2;
    polarity_t stage3;
    polarity_t next_level;

    // Stage one feeds only stage two; a bit moves once stages two and three agree.
    always_comb begin
        next_level = level;
        for (int i = 0; i < `POL_W; i++) begin
            if (stage2[i] == stage3[i]) begin
                next_level[i] = stage3[i];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level  <= '0;
        end else begin
            stage1 <= pins;
            stage2 <= stage1;
            stage3 <= stage2;
            level  <= next_level;
        end
    end
endmodule

// *** core/activity_blink.sv ***
// Link and activity indication for one port.
// Assumes link and frame come from logic on sys_clk.
`include "led_defines.svh"
module activity_blink #(
    parameter int BLINK_CYC = `ACT_BLINK_CYC
) (
    // Clock and reset
    input  wire logic  sys_clk,
    input  wire logic  sys_rst,
    // Port state
    input  wire logic  link,
    input  wire logic  frame,
    // Indication
    output logic       lit
);
    import led_pkg::*;

    localparam logic [`ACT_CNT_W-1:0] LAST = `ACT_CNT_W'(BLINK_CYC - 1);
    localparam logic [`ACT_CNT_W-1:0] HALF = `ACT_CNT_W'(BLINK_CYC / 2);

    logic [`ACT_CNT_W-1:0] count;
    logic [`ACT_CNT_W-1:0] next_count;
    logic                  next_lit;

    // A frame starts one off-then-on blink; frames during a blink merge into it.
    always_comb begin
        next_count = count;
        if (!link) begin
            next_count = '0;
        end else if (count != '0) begin
            next_count = count - 1'b1;
        end else if (frame) begin
            next_count = LAST;
        end
        next_lit = link && !(next_count > HALF);
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            count <= '0;
            lit   <= 1'b0;
        end else begin
            count <= next_count;
            lit   <= next_lit;
        end
    end
endmodule

// *** verification/led_board.sv ***
// Board model of the indicator pins: pull resistors through the LEDs and the strap sensing.
// Assumes the driver releases a pin by raising its enable-low and drives it otherwise.
module led_board #(
    parameter logic [4:0] PULL = 5'h15
) (
    // Driver side, bits 0-2 ports, 3 run, 4 error
    input  wire logic [4:0] level,
    input  wire logic [4:0] oe_n,
    // Board side
    output logic [4:0]      pin,
    output logic [4:0]      straps
);
    timeunit 1ns;
    timeprecision 1ps;

    // A released pin rests at its pull level, a driven one at the driven level.
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            pin[i] = oe_n[i] ? PULL[i] : level[i];
        end
    end

    // The straps are read off the same wires, so a driven pin would upset them.
    assign straps = pin;
endmodule

// *** verification/status_led_driver_test.sv ***
// Self-checking bench of the status indicator driver with a board model on its pins.
// Assumes the design package, the defines header and the board model are compiled first.
`include "led_defines.svh"

`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e); end end

module status_led_driver_test import led_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam polarity_t PULL = 5'h15;
    logic       sys_clk, sys_rst, hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans, ld_cfg;
    logic [2:0] hsize;
    addr_t      haddr;
    word_t      hwdata, hrdata, q;
    polarity_t  straps, pin, exp_pol;
    logic       run_state, error_state, ld_done, ld_err;
    logic       run_lvl, run_oe_n, err_lvl, err_oe_n, seen_off;
    port_vec_t  port_link, port_frame, pla, pla_oe_n;
    int         n_errors, cmp_count;

    status_led_driver #(.BLINK_CYC(16)) status_led_driver_i (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .indicator_polarity_straps(straps), .run_state(run_state), .error_state(error_state),
        .port_link(port_link), .port_frame(port_frame), .eeprom_load_done(ld_done),
        .eeprom_load_error(ld_err), .eeprom_core_config(ld_cfg), .run_indicator(run_lvl),
        .run_indicator_oe_n(run_oe_n), .error_indicator(err_lvl),
        .error_indicator_oe_n(err_oe_n), .port_link_activity_indicator(pla),
        .port_link_activity_indicator_oe_n(pla_oe_n));

    led_board #(.PULL(PULL)) led_board_i (
        .level({err_lvl, run_lvl, pla}), .oe_n({err_oe_n, run_oe_n, pla_oe_n}),
        .pin(pin), .straps(straps));

    always #2.5 sys_clk = ~sys_clk;

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One single AHB-Lite transfer; the wait on hready is bounded.
    task automatic bus(input logic wr, input addr_t a, input word_t d, output word_t r);
        int n;
        n = 0;
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= `HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        do begin @(posedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 100);
        r = hrdata;
        `CHK(hresp, 1'b0, "response")
        if (n >= 100) begin
            n_errors++;
            results();
        end
    endtask

    task automatic wr(input addr_t a, input word_t d);
        word_t r;
        bus(1'b1, a, d, r);
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic rd(input addr_t a, input word_t e);
        word_t r;
        bus(1'b0, a, 32'h0, r);
        `CHK(r, e, "read data")
    endtask

    task automatic settle();
        repeat (4) @(posedge sys_clk);
    endtask

    // Checks one pin: driven to its active level when lit, at rest otherwise.
    task automatic pin_is(input int i, input logic on);
        logic [4:0] oe;
        oe = {err_oe_n, run_oe_n, pla_oe_n};
        `CHK(oe[i], ~on, "pin enable")
        `CHK(pin[i], on ? exp_pol[i] : PULL[i], "pin level")
    endtask

    task automatic pulse(input logic load_done, input logic load_err, input logic [1:0] cfg);
        @(posedge sys_clk);
        ld_cfg <= cfg;
        ld_done <= load_done;
        ld_err <= load_err;
        @(posedge sys_clk);
        ld_done <= 1'b0;
        ld_err <= 1'b0;
        settle();
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        results();
    end

    initial begin
        sys_clk = 0; sys_rst = 1; hsel = 0; hwrite = 0; htrans = 0; hsize = 3'h2;
        haddr = 0; hwdata = 0; run_state = 0; error_state = 0; port_link = 0;
        port_frame = 0; ld_done = 0; ld_err = 0; ld_cfg = 0;
        n_errors = 0; cmp_count = 0;
        exp_pol = PULL ^ `STRAP_SHARED_MASK;
        repeat (6) @(posedge sys_clk);
        `CHK({err_oe_n, run_oe_n, pla_oe_n}, 5'h1f, "reset enables")
        sys_rst <= 1'b0;
        repeat (12) @(posedge sys_clk);
        rd(`OFS_HARDWARE_CONF, {27'h0, exp_pol});
        $display("test straps done");

        run_state <= 1'b1; settle();
        pin_is(3, 1'b1);
        run_state <= 1'b0; settle();
        pin_is(3, 1'b0);
        error_state <= 1'b1; settle();
        pin_is(4, 1'b0);
        wr(`OFS_CORE_CONF, 32'h1);
        pin_is(4, 1'b1);
        rd(`OFS_CORE_CONF, 32'h1);
        pulse(1'b1, 1'b0, 2'b10);
        rd(`OFS_CORE_CONF, 32'h2);
        pin_is(4, 1'b0);
        $display("test run and error done");

        wr(`OFS_CORE_CONF, 32'h3);
        run_state <= 1'b1; settle();
        pin_is(3, 1'b0);
        pin_is(4, 1'b1);
        error_state <= 1'b0; settle();
        pin_is(3, 1'b1);
        wr(`OFS_CORE_CONF, 32'h1);
        error_state <= 1'b1; settle();
        pin_is(3, 1'b1);
        $display("test combined mode done");

        wr(`OFS_RUN_OVERRIDE, 32'h1);
        pin_is(3, 1'b0);
        wr(`OFS_ERR_OVERRIDE, 32'h1);
        pin_is(4, 1'b0);
        run_state <= 1'b0;
        error_state <= 1'b0;
        wr(`OFS_RUN_OVERRIDE, 32'h3);
        pin_is(3, 1'b1);
        wr(`OFS_ERR_OVERRIDE, 32'h3);
        pin_is(4, 1'b1);
        wr(`OFS_RUN_OVERRIDE, 32'h0);
        wr(`OFS_ERR_OVERRIDE, 32'h0);
        pin_is(3, 1'b0);
        $display("test override done");

        port_link <= 3'h7;
        run_state <= 1'b1;
        error_state <= 1'b1;
        wr(`OFS_POWER_CONTROL, 32'h1);
        `CHK({err_oe_n, run_oe_n, pla_oe_n}, 5'h1f, "disabled")
        wr(`OFS_POWER_CONTROL, 32'h0);
        `CHK({err_oe_n, run_oe_n, pla_oe_n}, 5'h00, "enabled")
        $display("test disable done");

        wr(`OFS_CORE_CONF, 32'h0);
        pin_is(4, 1'b0);
        pulse(1'b0, 1'b1, 2'b00);
        pin_is(4, 1'b1);
        rd(`OFS_STATUS, 32'h0f);
        wr(`OFS_STATUS, 32'hffffffff);
        rd(`OFS_STATUS, 32'h0f);
        exp_pol = exp_pol | 5'h10;
        wr(`OFS_HARDWARE_CONF, {27'h0, exp_pol});
        `CHK(err_oe_n, 1'b1, "forced enable when active high")
        exp_pol = exp_pol & 5'h0f;
        wr(`OFS_HARDWARE_CONF, {27'h0, exp_pol});
        pin_is(4, 1'b1);
        pulse(1'b1, 1'b0, 2'b00);
        pin_is(4, 1'b0);
        $display("test eeprom error done");

        run_state <= 1'b0;
        error_state <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            port_link <= port_vec_t'(1 << i);
            settle();
            for (int j = 0; j < 3; j++) begin
                pin_is(j, i == j);
            end
            port_frame <= port_vec_t'(1 << i);
            @(posedge sys_clk);
            port_frame <= 3'h0;
            seen_off = 1'b0;
            repeat (30) begin
                @(posedge sys_clk);
                if (pla_oe_n[i] === 1'b1) seen_off = 1'b1;
            end
            `CHK(seen_off, 1'b1, "activity blink")
            pin_is(i, 1'b1);
        end
        port_link <= 3'h0; settle();
        pin_is(0, 1'b0);
        $display("test link activity done");

        wr(8'h20, 32'h5);
        rd(8'h20, 32'h0);
        rd(`OFS_POWER_CONTROL, 32'h0);
        $display("test unmapped done");
        results();
    end
endmodule
